//--- hw/uhr_pkg.sv
// Constants shared by the holding-register and interrupt-enable channel logic.
// Assumes a single 50 MHz clock and a host bus decoded to register strobes outside.
// Operation
// - Holding register feeds shifter when empty
// - Holding-empty flag sets on empty or transfer
// - Empty flag 0 while data queued
// - Receive read returns oldest byte, pops it
// - Falling edge starts 16x sample counter
// - Mid-start sample; low accepts, high discards
// - Enable bit 7 gates clear-to-send rise
// - Enable bit 6 gates request-to-send rise
// - Enable bit 5 gates Xoff received
// - Enable bit 4 is sleep; resets zero
// - Enable bit 3 gates modem change bits
// - Enable bit 2 gates line errors 1-4
// - Enable bit 1 gates transmit empty
// - Enable bit 0 gates receive data/trigger
// - Receive status clears below trigger level
// - Data ready sets on push, clears empty
// - Transmit interrupt clears on ident read/write
// - Channel interrupt on its own pin
// - Fifo control bit 0 selects fifo mode
package uhr_pkg;
    // ------------------------------------------------------------
    // Register offsets (host address bits 2..0)
    // ------------------------------------------------------------
    localparam logic [2:0] UHR_OFF_HOLDING   = 3'h0;
    localparam logic [2:0] UHR_OFF_IRQ_EN    = 3'h1;
    localparam logic [2:0] UHR_OFF_IDENT     = 3'h2;
    localparam logic [2:0] UHR_OFF_LINE_STAT = 3'h5;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] UHR_IRQ_EN_RST    = 8'h00;
    localparam logic [3:0] UHR_IDENT_NONE    = 4'h1;
    // ------------------------------------------------------------
    // Enable bit positions
    // ------------------------------------------------------------
    localparam int UHR_IE_RX    = 0;
    localparam int UHR_IE_TX    = 1;
    localparam int UHR_IE_LINE  = 2;
    localparam int UHR_IE_MODEM = 3;
    localparam int UHR_IE_SLEEP = 4;
    localparam int UHR_IE_XOFF  = 5;
    localparam int UHR_IE_RTS   = 6;
    localparam int UHR_IE_CTS   = 7;
    // ------------------------------------------------------------
    // Line status bit positions
    // ------------------------------------------------------------
    localparam int UHR_LS_DATA_READY = 0;
    localparam int UHR_LS_TX_EMPTY   = 5;
    localparam int UHR_LS_ALL_EMPTY  = 6;
    // ------------------------------------------------------------
    // Identification codes (priority encoded)
    // ------------------------------------------------------------
    localparam logic [3:0] UHR_ID_LINE  = 4'h6;
    localparam logic [3:0] UHR_ID_RX    = 4'h4;
    localparam logic [3:0] UHR_ID_TX    = 4'h2;
    localparam logic [3:0] UHR_ID_MODEM = 4'h0;
    localparam logic [3:0] UHR_ID_FLOW  = 4'h8;
    // ------------------------------------------------------------
    // Timing: receive oversampling
    // ------------------------------------------------------------
    localparam int         UHR_OVERSAMPLE = 16;
    localparam logic [3:0] UHR_MID_START  = 4'h7;
    localparam int         UHR_FIFO_DEPTH = 8;
    localparam int         UHR_DATA_W     = 8;
endpackage

//--- hw/uhr_fifo.sv
// Flip-flop FIFO with valid/ready on both sides.
// Assumes one clock; write and read may occur in the same cycle.
`timescale 1ns/1ps
module uhr_fifo
    import uhr_pkg::*;
#(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk_i,
    input  wire logic             rst_n_i,
    input  wire logic             flush_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    output logic [WIDTH-1:0]      out_data_o,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic [$clog2(DEPTH):0] count_o
);
    // ------------------------------------------------------------
    // Storage and pointers
    // ------------------------------------------------------------
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];     // Entry storage
    logic [AW-1:0]    wr_ptr;          // Next write slot
    logic [AW-1:0]    rd_ptr;          // Oldest entry
    logic [AW:0]      count;           // Fill level
    logic             push;            // Accepted write
    logic             pop;             // Accepted read

    initial begin
        if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
            $error("uhr_fifo: DEPTH must be a power of two >= 2");
    end

    // Full refuses writes so queued data is never overwritten
    assign push        = in_valid_i && (count != DEPTH[AW:0]);
    assign pop         = out_ready_i && (count != '0);
    assign in_ready_o  = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign count_o     = count;

    // Storage write; no reset needed on data
    always_ff @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    // Pointer and level bookkeeping
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else if (flush_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop)  rd_ptr <= rd_ptr + 1'b1;
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

//--- hw/uhr_start_det.sv
// Start-bit validator: falling edge arms a 16x counter, mid-bit sample checks.
// Assumes sample_tick_i pulses once per 16x sample clock and rx_i is synchronous.
`timescale 1ns/1ps
module uhr_start_det
    import uhr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic sample_tick_i,
    input  wire logic rx_i,
    input  wire logic busy_i,
    output logic      start_ok_o,
    output logic      start_bad_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic       rx_q;      // Previous line level
    logic       armed;     // Counting toward mid start
    logic [3:0] cnt;       // Sample clocks since edge

    // Edge history
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rx_q <= 1'b1;
        else          rx_q <= rx_i;
    end

    // Counter run from falling edge mid-bit check
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            armed       <= 1'b0;
            cnt         <= '0;
            start_ok_o  <= 1'b0;
            start_bad_o <= 1'b0;
        end else begin
            start_ok_o  <= 1'b0;
            start_bad_o <= 1'b0;
            if (!armed) begin
                if (rx_q && !rx_i && !busy_i) begin   // Possible start
                    armed <= 1'b1;
                    cnt   <= '0;
                end
            end else if (sample_tick_i) begin
                // Seven whole ticks plus the half tick of edge phase
                if (cnt == UHR_MID_START) begin
                    armed <= 1'b0;
                    if (!rx_i) start_ok_o  <= 1'b1;   // Still low: real
                    else       start_bad_o <= 1'b1;   // Glitch: drop
                end else begin
                    cnt <= cnt + 4'h1;
                end
            end
        end
    end
endmodule

//--- hw/uhr_channel.sv
// One channel: holding registers, start validation, interrupt enable and ident.
// Assumes the host bus is decoded into read/write strobes with a 3-bit address,
// and that bit timing, shifting and error detection sit around this block.
`timescale 1ns/1ps
module uhr_channel
    import uhr_pkg::*;
#(
    parameter int DEPTH = UHR_FIFO_DEPTH
) (
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Host side
    input  wire logic [2:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] host_data_bus_i,
    output logic [7:0]      host_data_bus_o,
    // Mode and trigger
    input  wire logic       fifo_enable_i,
    input  wire logic [3:0] rx_trigger_i,
    // Transmit shifter side
    input  wire logic       tx_shifter_ready_i,
    input  wire logic       tx_shifter_idle_i,
    output logic            tx_shifter_load_o,
    output logic [7:0]      tx_shifter_data_o,
    // Receive shifter side
    input  wire logic       sample_tick_i,
    input  wire logic       rx_line_i,
    input  wire logic       rx_busy_i,
    input  wire logic       rx_shifter_done_i,
    input  wire logic [7:0] rx_shifter_data_i,
    output logic            rx_start_ok_o,
    output logic            rx_false_start_o,
    // Event sources
    input  wire logic [3:0] line_errors_i,
    input  wire logic [3:0] modem_delta_i,
    input  wire logic       cts_i,
    input  wire logic       rts_i,
    input  wire logic       xoff_seen_i,
    // Outputs
    output logic            sleep_o,
    output logic            rx_overrun_o,
    output logic            irq_out_o
);
    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    localparam int CW = $clog2(DEPTH) + 1;
    initial begin
        if (DEPTH < 2 || DEPTH > 15)
            $error("uhr_channel: DEPTH out of range 2..15");
    end

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]    interrupt_enable;    // Host enable/sleep bits
    logic [7:0]    tx_q_data;           // Transmit queue head
    logic          tx_q_valid;          // Transmit queue not empty
    logic          tx_q_in_ready;       // Transmit queue has room
    logic [CW-1:0] tx_count;            // Transmit fill
    logic [7:0]    rx_q_data;           // Oldest received byte
    logic          rx_q_valid;          // Receive data ready
    logic          rx_q_in_ready;       // Receive queue has room
    logic [CW-1:0] rx_count;            // Receive fill
    logic          wr_hold;             // Host write to transmit
    logic          rd_hold;             // Host read of receive
    logic          rd_ident;            // Host read of ident
    logic          tx_limit;            // Queue capacity in use
    logic          rx_limit;            // Capacity for this mode
    logic          tx_push;             // Byte enters transmit queue
    logic          tx_pop;              // Byte moves to shifter
    logic          tx_empty_evt;        // Pending transmit event
    logic          cts_q;               // Previous clear-to-send
    logic          rts_q;               // Previous request-to-send
    logic          cts_evt;             // Sticky clear-to-send rise
    logic          rts_evt;             // Sticky request-to-send rise
    logic          rx_pending;          // Receive source active
    logic          line_pending;        // Line error source
    logic          modem_pending;       // Modem change source
    logic          flow_pending;        // Flow events
    logic [3:0]    ident;               // Current ident code
    logic          next_irq;            // Combined interrupt
    logic          fifo_mode_q;         // Mode of last cycle
    logic          mode_flip;           // Mode change flushes

    // ------------------------------------------------------------
    // Host strobe decode
    // ------------------------------------------------------------
    assign wr_hold  = wr_i && (addr_i == UHR_OFF_HOLDING);
    assign rd_hold  = rd_i && (addr_i == UHR_OFF_HOLDING);
    assign rd_ident = rd_i && (addr_i == UHR_OFF_IDENT);

    // Non-fifo mode uses only one slot per direction
    assign tx_limit = fifo_enable_i ? tx_q_in_ready : (tx_count == '0);
    assign rx_limit = fifo_enable_i ? rx_q_in_ready : (rx_count == '0);
    assign mode_flip = fifo_mode_q != fifo_enable_i;

    // Write accepted only when a slot is free
    assign tx_push = wr_hold && tx_limit;
    // Byte moves from holding into shifter when it can take it
    assign tx_pop  = tx_q_valid && tx_shifter_ready_i;

    // ------------------------------------------------------------
    // Transmit queue (holding register / fifo)
    // ------------------------------------------------------------
    uhr_fifo #(
        .WIDTH (UHR_DATA_W),
        .DEPTH (DEPTH == 8 ? 8 : (1 << $clog2(DEPTH)))
    ) u_tx_q (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (mode_flip),
        .in_data_i   (host_data_bus_i),
        .in_valid_i  (tx_push),
        .in_ready_o  (tx_q_in_ready),
        .out_data_o  (tx_q_data),
        .out_valid_o (tx_q_valid),
        .out_ready_i (tx_shifter_ready_i),
        .count_o     (tx_count)
    );

    // ------------------------------------------------------------
    // Receive queue; overrun if shifter finishes with no room
    // ------------------------------------------------------------
    uhr_fifo #(
        .WIDTH (UHR_DATA_W),
        .DEPTH (DEPTH == 8 ? 8 : (1 << $clog2(DEPTH)))
    ) u_rx_q (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .flush_i     (mode_flip),
        .in_data_i   (rx_shifter_data_i),
        .in_valid_i  (rx_shifter_done_i && rx_limit),
        .in_ready_o  (rx_q_in_ready),
        .out_data_o  (rx_q_data),
        .out_valid_o (rx_q_valid),
        .out_ready_i (rd_hold),            // Read pops oldest
        .count_o     (rx_count)
    );

    // ------------------------------------------------------------
    // Start-bit validation
    // ------------------------------------------------------------
    uhr_start_det u_start (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .sample_tick_i (sample_tick_i),
        .rx_i          (rx_line_i),
        .busy_i        (rx_busy_i),
        .start_ok_o    (rx_start_ok_o),
        .start_bad_o   (rx_false_start_o)
    );

    // ------------------------------------------------------------
    // Mode tracking
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) fifo_mode_q <= 1'b0;
        else          fifo_mode_q <= fifo_enable_i;
    end

    // ------------------------------------------------------------
    // Interrupt enable register; all bits reset to zero
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            interrupt_enable <= UHR_IRQ_EN_RST;
        end else if (wr_i && addr_i == UHR_OFF_IRQ_EN) begin
            interrupt_enable <= host_data_bus_i;
        end
    end

    // Sleep follows its enable bit
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) sleep_o <= 1'b0;
        else          sleep_o <= interrupt_enable[UHR_IE_SLEEP];
    end

    // ------------------------------------------------------------
    // Shifter handoff registered so outputs come from flops
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_shifter_load_o <= 1'b0;
            tx_shifter_data_o <= '0;
        end else begin
            tx_shifter_load_o <= tx_pop;
            if (tx_pop) tx_shifter_data_o <= tx_q_data;
        end
    end

    // Overrun pulse: completed byte with no room
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) rx_overrun_o <= 1'b0;
        else          rx_overrun_o <= rx_shifter_done_i && !rx_limit;
    end

    // ------------------------------------------------------------
    // Transmit-empty event: set when a pop empties the queue,
    // cleared by ident read or new write; set wins over ident read, write wins over set
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_empty_evt <= 1'b1;
        end else if (tx_pop && tx_count == CW'(1) && !tx_push) begin
            tx_empty_evt <= 1'b1;
        end else if (tx_push || (rd_ident && ident == UHR_ID_TX)) begin
            tx_empty_evt <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Edge-detected flow events; rise wins over ident-read clear
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cts_q   <= 1'b0;
            rts_q   <= 1'b0;
            cts_evt <= 1'b0;
            rts_evt <= 1'b0;
        end else begin
            cts_q <= cts_i;
            rts_q <= rts_i;
            if (cts_i && !cts_q)                     cts_evt <= 1'b1;
            else if (rd_ident && ident == UHR_ID_FLOW) cts_evt <= 1'b0;
            if (rts_i && !rts_q)                     rts_evt <= 1'b1;
            else if (rd_ident && ident == UHR_ID_FLOW) rts_evt <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Source qualification by enable bits
    // ------------------------------------------------------------
    // Trigger in fifo mode, any data otherwise
    assign rx_pending    = interrupt_enable[UHR_IE_RX] &&
                           (fifo_enable_i ? (rx_count >= CW'(rx_trigger_i)) && (rx_trigger_i != '0)
                                          : rx_q_valid);
    assign line_pending  = interrupt_enable[UHR_IE_LINE] && (|line_errors_i);
    assign modem_pending = interrupt_enable[UHR_IE_MODEM] && (|modem_delta_i);
    assign flow_pending  = (interrupt_enable[UHR_IE_XOFF] && xoff_seen_i) ||
                           (interrupt_enable[UHR_IE_CTS] && cts_evt) ||
                           (interrupt_enable[UHR_IE_RTS] && rts_evt);

    // Transmit source: holding or fifo empty
    logic tx_pending;
    assign tx_pending = interrupt_enable[UHR_IE_TX] && tx_empty_evt && !tx_q_valid;

    // ------------------------------------------------------------
    // Priority ident and combined request
    // ------------------------------------------------------------
    always_comb begin
        if (line_pending)       ident = UHR_ID_LINE;
        else if (rx_pending)    ident = UHR_ID_RX;
        else if (tx_pending)    ident = UHR_ID_TX;
        else if (modem_pending) ident = UHR_ID_MODEM;
        else if (flow_pending)  ident = UHR_ID_FLOW;
        else                    ident = UHR_IDENT_NONE;
        next_irq = (ident != UHR_IDENT_NONE);
    end

    // Own interrupt pin per channel
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) irq_out_o <= 1'b0;
        else          irq_out_o <= next_irq;
    end

    // ------------------------------------------------------------
    // Read data mux, registered
    // ------------------------------------------------------------
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            host_data_bus_o <= '0;
        end else if (rd_i) begin
            unique case (addr_i)
                UHR_OFF_HOLDING:   host_data_bus_o <= rx_q_data;
                UHR_OFF_IRQ_EN:    host_data_bus_o <= interrupt_enable;
                UHR_OFF_IDENT:     host_data_bus_o <= {fifo_enable_i, fifo_enable_i, 2'b00, ident};
                UHR_OFF_LINE_STAT: begin
                    host_data_bus_o <= '0;
                    host_data_bus_o[UHR_LS_DATA_READY] <= rx_q_valid;
                    host_data_bus_o[UHR_LS_TX_EMPTY]   <= !tx_q_valid;
                    host_data_bus_o[UHR_LS_ALL_EMPTY]  <= !tx_q_valid && tx_shifter_idle_i;
                    host_data_bus_o[4:1]               <= line_errors_i;
                end
                default:           host_data_bus_o <= '0;
            endcase
        end
    end
endmodule

//--- test/uhr_channel_checker.sv
// Port assertions for one channel.
// Assumes it is bound onto every uhr_channel instance.
`timescale 1ns/1ps
module uhr_channel_checker
    import uhr_pkg::*;
(
    input wire logic       clk_i, rst_n_i, wr_i, rd_i, tx_shifter_ready_i, tx_shifter_load_o,
    input wire logic       sample_tick_i, rx_line_i, rx_start_ok_o, rx_false_start_o, sleep_o,
    input wire logic [2:0] addr_i,
    input wire logic [7:0] host_data_bus_i, host_data_bus_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    wire ie_wr = wr_i && addr_i == UHR_OFF_IRQ_EN; // Host write to the enable register
    a_sleep_copy: assert property (ie_wr |-> ##2 sleep_o == $past(host_data_bus_i[4], 2))
        else $error("sleep");
    a_sleep_hold: assert property (!ie_wr |-> ##2 $stable(sleep_o)) else $error("sleep moved");
    a_read_hold: assert property (!rd_i |=> $stable(host_data_bus_o)) else $error("read moved");
    a_start_good: assert property (rx_start_ok_o |-> $past(sample_tick_i) && !$past(rx_line_i)) else $error("ok");
    a_start_false: assert property (rx_false_start_o |-> $past(sample_tick_i) && $past(rx_line_i)) else $error("bad");
    a_start_once: assert property (rx_start_ok_o |-> !rx_false_start_o ##1 !rx_start_ok_o) else $error("ok2");
    a_false_once: assert property (rx_false_start_o |=> !rx_false_start_o) else $error("bad2");
    a_load_ready: assert property (tx_shifter_load_o |-> $past(tx_shifter_ready_i)) else $error("load");
endmodule
bind uhr_channel uhr_channel_checker i_uhr_channel_checker (.*);

//--- test/uhr_tx_partner.sv
// Transmit shifter model: takes a byte, then stays busy a few cycles.
// Assumes one clock and the channel's registered load pulse.
`timescale 1ns/1ps
module uhr_tx_partner (
    input  wire logic clk_i, rst_n_i, stall_i, load_i,
    output logic      ready_o, idle_o
);
    logic [2:0] busy; // Cycles left, far shorter than a frame
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) busy <= 3'h0;
        else if (load_i) busy <= 3'h5;
        else if (busy != 3'h0) busy <= busy - 3'h1;
    end
    assign idle_o  = busy == 3'h0;
    // Stall lets the bench fill the queue; a load in flight already takes the shifter
    assign ready_o = idle_o && !stall_i && !load_i;
endmodule

//--- test/uhr_channel_tb.sv
// Bench for one channel: host accesses, shifter model, receive pushes.
// Assumes package, design, model and checker are compiled first.
`timescale 1ns/1ps
module uhr_channel_tb
    import uhr_pkg::*;
;
    logic clk_i = 1'b0, rst_n_i = 1'b0, wr = 1'b0, rd = 1'b0, tick = 1'b0, rxl = 1'b1, done = 1'b0;
    logic stall = 1'b1, fen = 1'b1, rdy, idle, load, okp, badp, irq, slp, ovr;
    logic [2:0] addr = 3'h0;
    logic [4:0] src = 5'h00; // Clear-to-send, request-to-send, xoff, modem, line
    logic [7:0] wd = 8'h00, rxd = 8'h00, rdo, rdata, txd, sent[$];
    int mismatches = 0, checks_done = 0, n_ok = 0, n_bad = 0, n_ovr = 0, bits[5] = '{7, 6, 5, 3, 2};
    always #10 clk_i = ~clk_i;
    always @(negedge clk_i) tick <= ~tick; // Sample tick every other cycle
    always @(posedge clk_i) begin // Pulses counted in the cycle they stand
        if (load === 1'b1) sent.push_back(txd);
        n_ok += int'(okp === 1'b1);
        n_bad += int'(badp === 1'b1);
        n_ovr += int'(ovr === 1'b1);
    end
    uhr_channel i_uhr_channel (.clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr), .wr_i(wr), .rd_i(rd),
        .host_data_bus_i(wd), .host_data_bus_o(rdo), .fifo_enable_i(fen), .rx_trigger_i(4'h2),
        .tx_shifter_ready_i(rdy), .tx_shifter_idle_i(idle), .tx_shifter_load_o(load), .tx_shifter_data_o(txd),
        .sample_tick_i(tick), .rx_line_i(rxl), .rx_busy_i(1'b0), .rx_shifter_done_i(done),
        .rx_shifter_data_i(rxd), .rx_start_ok_o(okp), .rx_false_start_o(badp), .line_errors_i({4{src[4]}}),
        .modem_delta_i({4{src[3]}}), .cts_i(src[0]), .rts_i(src[1]), .xoff_seen_i(src[2]), .sleep_o(slp),
        .rx_overrun_o(ovr), .irq_out_o(irq));
    uhr_tx_partner i_uhr_tx_partner (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .load_i(load),
        .ready_o(rdy), .idle_o(idle));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        mismatches += int'(seen !== exp);
        if (seen !== exp) $display("mismatch at %0t: got %h want %h", $time, seen, exp);
    endtask
    // One strobe, held over its sampling edge; read data taken once settled
    task automatic bus(input logic w, input logic [2:0] a, input logic [7:0] d);
        {addr, wd, wr, rd} = {a, d, w, !w};
        @(negedge clk_i) {wr, rd} = 2'b00;
        @(negedge clk_i) rdata = rdo;
    endtask
    task automatic push(input logic [7:0] d);
        {rxd, done} = {d, 1'b1};
        @(negedge clk_i) done = 1'b0;
        @(negedge clk_i);
    endtask
    task automatic t_reg; // Reset value, every enable bit, sleep copy
        for (int i = 0; i < 9; i++) begin
            bus(0, UHR_OFF_IRQ_EN, 8'h00);
            check(rdata, 9'h001 << i >> 1);
            check(slp, i == 5);
            bus(1, UHR_OFF_IRQ_EN, 8'h01 << i);
        end
    endtask
    task automatic t_src; // Each flow, modem and line-error source reaches the pin only while enabled
        for (int k = 0; k < 5; k++) begin
            src[k] = 1'b1;
            bus(0, UHR_OFF_IRQ_EN, 8'h00);
            check(irq, 1'b0);
            bus(1, UHR_OFF_IRQ_EN, 8'h01 << bits[k]);
            check(irq, 1'b1);
            src[k] = 1'b0;
            bus(0, UHR_OFF_IDENT, 8'h00);
            check(irq, 1'b0);
            bus(1, UHR_OFF_IRQ_EN, 8'h00);
        end
    endtask
    task automatic t_tx; // Overfill while stalled, drain in order, clear by ident
        for (int i = 0; i < 10; i++) bus(1, UHR_OFF_HOLDING, 8'h30 + 8'(i));
        bus(0, UHR_OFF_LINE_STAT, 8'h00);
        check(rdata[UHR_LS_TX_EMPTY], 1'b0);
        stall = 1'b0;
        repeat (80) @(negedge clk_i);
        for (int i = 0; i < 8; i++) check(sent[i], 8'h30 + 8'(i));
        check(sent.size(), 8);
        bus(1, UHR_OFF_IRQ_EN, 8'h02);
        check(irq, 1'b1);
        bus(0, UHR_OFF_IDENT, 8'h00);
        check(rdata[3:0], UHR_ID_TX);
        check(irq, 1'b0);
    endtask
    task automatic t_rx; // Trigger of two, oldest first
        bus(1, UHR_OFF_IRQ_EN, 8'h01);
        push(8'h5a);
        check(irq, 1'b0);
        push(8'ha6);
        check(irq, 1'b1);
        bus(0, UHR_OFF_HOLDING, 8'h00);
        check(rdata, 8'h5a);
        check(irq, 1'b0);
        bus(0, UHR_OFF_HOLDING, 8'h00);
        check(rdata, 8'ha6);
        bus(0, UHR_OFF_LINE_STAT, 8'h00);
        check(rdata[UHR_LS_DATA_READY], 1'b0);
    endtask
    task automatic t_one; // Single-register mode: one slot, second byte overruns
        fen = 1'b0;
        bus(1, UHR_OFF_IRQ_EN, 8'h01);
        push(8'hc3);
        check(irq, 1'b1);
        push(8'h3c);
        check(n_ovr, 1);
        bus(0, UHR_OFF_HOLDING, 8'h00);
        check(rdata, 8'hc3);
        check(irq, 1'b0);
    endtask
    task automatic t_start; // A held start bit, then a short glitch
        rxl = 1'b0;
        repeat (40) @(negedge clk_i);
        rxl = 1'b1;
        repeat (40) @(negedge clk_i);
        rxl = 1'b0;
        repeat (4) @(negedge clk_i);
        rxl = 1'b1;
        repeat (40) @(negedge clk_i);
        check(n_ok, 1);
        check(n_bad, 1);
    endtask
    task automatic give_verdict;
        if (mismatches == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin // Watchdog far past the few hundred cycles needed
        #200us;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (10) @(negedge clk_i);
        rst_n_i = 1'b1;
        @(negedge clk_i);
        t_reg();
        t_src();
        t_tx();
        t_rx();
        t_one();
        t_start();
        give_verdict();
    end
endmodule
